// ==== rtl/mbra_top.v ====
// Multibyte register field access: atomic and non-atomic fields in repeated blocks
`include "mbra_consts.vh"

module mbra_top (
   input  wire        clk_i,
   input  wire        arst_n_i,
   input  wire        wr_en_i,
   input  wire [7:0]  wr_addr_i,
   input  wire [7:0]  wr_data_i,
   input  wire [7:0]  rd_addr_i,
   output reg  [7:0]  rd_data_o,
   output reg  [31:0] atom0_o,
   output reg  [31:0] plain0_o,
   output reg  [31:0] atom1_o,
   output reg  [31:0] plain1_o,
   output reg         atom_upd_o
);

   // Field and staging widths: word fields, top byte never staged
   localparam FIELD_W = `MBRA_WORD_W;
   localparam STAGE_W = `MBRA_WORD_W - `MBRA_BYTE_W;

   // Reset release synchroniser; the n in the names marks active low
   reg               rst_meta_n_r;
   reg               rst_n_r;

   // Staging buffers for the lower bytes of the atomic fields
   reg [STAGE_W-1:0] stage0_r;
   reg [STAGE_W-1:0] stage1_r;

   // Next values of every register but the reset synchroniser
   reg [STAGE_W-1:0] stage0_nxt;
   reg [STAGE_W-1:0] stage1_nxt;
   reg [FIELD_W-1:0] atom0_nxt;
   reg [FIELD_W-1:0] atom1_nxt;
   reg [FIELD_W-1:0] plain0_nxt;
   reg [FIELD_W-1:0] plain1_nxt;
   reg               upd_nxt;
   reg [7:0]         rd_nxt;

   // Decode: instance index from base plus k times stride
   function [1:0] blk_hit;                              // Hit flag, instance
      input [7:0] a;
      reg   [7:0] rel;
      begin
         rel = a - `MBRA_BLK_BASE;
         if (a >= `MBRA_BLK_BASE &&
             rel < (`MBRA_BLK_STRIDE * `MBRA_BLK_COUNT))
            blk_hit = {1'b1, rel[3]};
         else
            blk_hit = 2'b00;
      end
   endfunction

   // Byte lane of a field (bits 7:0 at lowest address)
   function [31:0] put_byte;
      input [31:0] f;
      input [1:0]  lane;
      input [7:0]  d;
      begin
         put_byte = f;
         put_byte[lane*8 +: 8] = d;
      end
   endfunction

   // Stage one lower byte of an atomic field into its buffer
   function [23:0] put_stage;
      input [23:0] s;
      input [1:0]  lane;
      input [7:0]  d;
      reg   [31:0] t;
      begin
         t         = put_byte({8'h00, s}, lane, d);
         put_stage = t[23:0];
      end
   endfunction

   // Pick one byte lane of an applied field for the read path
   function [7:0] get_byte;
      input [31:0] f;
      input [1:0]  lane;
      begin
         get_byte = f[lane*8 +: 8];
      end
   endfunction

   // One-hot instance strobe: bit k for instance k
   function [1:0] inst_sel;
      input en;
      input inst;
      begin
         inst_sel = {en && inst, en && !inst};
      end
   endfunction

   // Write and read address decode
   wire [1:0] wh      = blk_hit(wr_addr_i);
   wire [1:0] rh      = blk_hit(rd_addr_i);
   wire [2:0] wo      = wr_addr_i[2:0];
   wire [2:0] ro      = rd_addr_i[2:0];
   wire       w_hit   = wh[1];
   wire       w_inst  = wh[0];
   wire       r_hit   = rh[1];
   wire       r_inst  = rh[0];
   wire       w_atom  = wr_en_i && w_hit && (wo < `MBRA_OFS_PLAIN);
   wire       w_plain = wr_en_i && w_hit && (wo >= `MBRA_OFS_PLAIN);
   wire       w_low   = w_atom && (wo[1:0] != `MBRA_TOP_LANE);
   wire       w_top   = w_atom && (wo[1:0] == `MBRA_TOP_LANE);
   wire       r_plain = (ro >= `MBRA_OFS_PLAIN);

   // Per-instance strobes
   wire [1:0] stage_we  = inst_sel(w_low, w_inst);
   wire [1:0] commit_we = inst_sel(w_top, w_inst);
   wire [1:0] plain_we  = inst_sel(w_plain, w_inst);

   // Reset synchroniser: asserts at once, releases after two edges
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta_n_r <= 1'b0;
         rst_n_r      <= 1'b0;
      end else begin
         rst_meta_n_r <= 1'b1;
         rst_n_r      <= rst_meta_n_r;
      end
   end

   // Staging next value: lower bytes wait here, the latest write wins
   always @* begin
      stage0_nxt = stage0_r;
      stage1_nxt = stage1_r;
      if (stage_we[0]) begin
         stage0_nxt = put_stage(stage0_r, wo[1:0], wr_data_i);
      end
      if (stage_we[1]) begin
         stage1_nxt = put_stage(stage1_r, wo[1:0], wr_data_i);
      end
   end

   // Atomic next value: the top byte write applies the whole field at once
   always @* begin
      atom0_nxt = atom0_o;
      atom1_nxt = atom1_o;
      upd_nxt   = w_top;
      if (commit_we[0]) begin
         atom0_nxt = {wr_data_i, stage0_r};
      end
      if (commit_we[1]) begin
         atom1_nxt = {wr_data_i, stage1_r};
      end
   end

   // Non-atomic next value: each written byte takes effect on its own
   always @* begin
      plain0_nxt = plain0_o;
      plain1_nxt = plain1_o;
      if (plain_we[0]) begin
         plain0_nxt = put_byte(plain0_o, wo[1:0], wr_data_i);
      end
      if (plain_we[1]) begin
         plain1_nxt = put_byte(plain1_o, wo[1:0], wr_data_i);
      end
   end

   // Read next value: applied fields only, unmapped reads give zero
   always @* begin
      rd_nxt = 8'h00;
      if (r_hit) begin
         case ({r_plain, r_inst})
            2'b00:   rd_nxt = get_byte(atom0_o, ro[1:0]);
            2'b01:   rd_nxt = get_byte(atom1_o, ro[1:0]);
            2'b10:   rd_nxt = get_byte(plain0_o, ro[1:0]);
            2'b11:   rd_nxt = get_byte(plain1_o, ro[1:0]);
            default: rd_nxt = 8'h00;
         endcase
      end
   end

   // Staging buffers
   always @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         stage0_r <= `MBRA_RST_STAGE;
         stage1_r <= `MBRA_RST_STAGE;
      end else begin
         stage0_r <= stage0_nxt;
         stage1_r <= stage1_nxt;
      end
   end

   // Applied atomic fields
   always @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         atom0_o <= `MBRA_RST_ATOM;
         atom1_o <= `MBRA_RST_ATOM;
      end else begin
         atom0_o <= atom0_nxt;
         atom1_o <= atom1_nxt;
      end
   end

   // Commit pulse, one cycle after the top byte write
   always @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         atom_upd_o <= 1'b0;
      end else begin
         atom_upd_o <= upd_nxt;
      end
   end

   // Applied non-atomic fields
   always @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         plain0_o <= `MBRA_RST_PLAIN;
         plain1_o <= `MBRA_RST_PLAIN;
      end else begin
         plain0_o <= plain0_nxt;
         plain1_o <= plain1_nxt;
      end
   end

   // Read data register; a read in the write cycle sees the old value
   always @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rd_data_o <= 8'h00;
      end else begin
         rd_data_o <= rd_nxt;
      end
   end

endmodule

// ==== include/mbra_consts.vh ====
// Constants for the multibyte register field access block
// Operation
// - Least significant byte of a multi-byte field sits at its base address.
// - Bits number from 0 at LSB; bits 7:0 low address, 15:8 next.
// - Atomic field lower bytes are staged, not applied until top byte written.
// - Writing atomic top byte applies staged bytes plus top byte at once.
// - Non-atomic field bytes take effect immediately and independently.
// - Block instance k sits at base plus k times stride.
// - Byte 8, half-word 16, word 32, double-word 64 bits.
// - Names with n prefix are active low, others active high; the code marks active low with an n suffix (arst_n_i).
`ifndef MBRA_CONSTS_VH
`define MBRA_CONSTS_VH
`define MBRA_BYTE_W      8
`define MBRA_HWORD_W     16
`define MBRA_WORD_W      32
`define MBRA_DWORD_W     64
`define MBRA_ADDR_W      8
`define MBRA_BLK_BASE    8'h10
`define MBRA_BLK_STRIDE  8'h08
`define MBRA_BLK_COUNT   2
`define MBRA_OFS_ATOM    3'h0
`define MBRA_OFS_PLAIN   3'h4
`define MBRA_TOP_LANE    2'h3
`define MBRA_RST_STAGE   24'h000000
`define MBRA_RST_ATOM    32'h00000000
`define MBRA_RST_PLAIN   32'h00000000
`endif

// ==== bench/mbra_properties.sv ====
// Checker for the byte field access block
module mbra_properties (
   input wire logic        clk_i,
   input wire logic        arst_n_i,
   input wire logic        wr_en_i,
   input wire logic [7:0]  wr_addr_i,
   input wire logic [7:0]  wr_data_i,
   input wire logic [7:0]  rd_addr_i,
   input wire logic [7:0]  rd_data_o,
   input wire logic [31:0] atom0_o,
   input wire logic [31:0] plain0_o,
   input wire logic [31:0] atom1_o,
   input wire logic [31:0] plain1_o,
   input wire logic        atom_upd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // Atomic commit steps: the top byte write, then the applied field
   sequence s_top0_wr;
      wr_en_i && wr_addr_i == 8'h13;
   endsequence
   sequence s_top0_applied;
      atom_upd_o && atom0_o[31:24] == $past(wr_data_i);
   endsequence
   a_plain_low: assert property (wr_en_i && wr_addr_i == 8'h14
      |=> plain0_o == {$past(plain0_o[31:8]), $past(wr_data_i)}) else $error("plain0");
   a_plain_top: assert property (wr_en_i && wr_addr_i == 8'h1f
      |=> plain1_o[31:24] == $past(wr_data_i)) else $error("plain1");
   a_atom_stage: assert property (wr_en_i && wr_addr_i inside {8'h10, 8'h11, 8'h12}
      |=> $stable(atom0_o)) else $error("stage");
   a_atom_commit: assert property (s_top0_wr |=> s_top0_applied)
      else $error("commit");
   a_upd_cause: assert property (atom_upd_o
      |-> $past(wr_en_i && wr_addr_i[7:4] == 4'h1 && wr_addr_i[2:0] == 3'h3)) else $error("upd");
   a_wr_unmapped: assert property (wr_en_i && wr_addr_i[7:4] != 4'h1
      |=> $stable({atom0_o, plain0_o, atom1_o, plain1_o})) else $error("unmapped");
   a_rd_unmapped: assert property (rd_addr_i[7:4] != 4'h1 |=> rd_data_o == 8'h00)
      else $error("rd zero");
   a_rd_plain: assert property (rd_addr_i == 8'h1c
      |=> rd_data_o == $past(plain1_o[7:0])) else $error("rd byte");
endmodule
bind mbra_top mbra_properties u_props (.*);

// ==== bench/test_mbra_top.sv ====
// Self-checking bench for the byte field access block
module test_mbra_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 0, arst_n_i = 0, wr_en_i = 0, go = 0, eu = 0, atom_upd_o;
   logic [7:0]  wr_addr_i = 0, wr_data_i = 0, rd_addr_i = 0, rd_data_o, er = 0;
   logic [31:0] atom0_o, plain0_o, atom1_o, plain1_o;
   logic [7:0]  am [16] = '{default: 8'h00}, st [16] = '{default: 8'h00};
   logic [127:0] ex = 0;
   int          fail_count = 0, total_checks = 0, cyc = 0;
   mbra_top uut (
      .clk_i      (clk_i),
      .arst_n_i   (arst_n_i),
      .wr_en_i    (wr_en_i),
      .wr_addr_i  (wr_addr_i),
      .wr_data_i  (wr_data_i),
      .rd_addr_i  (rd_addr_i),
      .rd_data_o  (rd_data_o),
      .atom0_o    (atom0_o),
      .plain0_o   (plain0_o),
      .atom1_o    (atom1_o),
      .plain1_o   (plain1_o),
      .atom_upd_o (atom_upd_o)
   );
   initial forever #2.5 clk_i = ~clk_i;
   task automatic ck(string n, logic [127:0] e, g);
      total_checks++;
      if (e !== g) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic finish_test;
      if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Reference model: applied bytes am, staged atomic bytes st
   always @(posedge clk_i) if (go) begin
      eu = 0;
      er = rd_addr_i[7:4] == 4'h1 ? am[rd_addr_i[3:0]] : 8'h00;
      if (wr_en_i && wr_addr_i[7:4] == 4'h1) begin
         if (wr_addr_i[2]) am[wr_addr_i[3:0]] = wr_data_i;
         else if (wr_addr_i[1:0] != 2'h3) st[wr_addr_i[3:0]] = wr_data_i;
         else begin
            for (int j = 0; j < 3; j++) am[{wr_addr_i[3:2], 2'(j)}] = st[{wr_addr_i[3:2], 2'(j)}];
            am[wr_addr_i[3:0]] = wr_data_i;
            eu = 1;
         end
      end
      for (int j = 0; j < 16; j++) ex[j*8 +: 8] = am[j];
   end
   // Compare at the falling edge once outputs have settled
   always @(negedge clk_i) if (go) begin
      ck("fields", ex, {plain1_o, atom1_o, plain0_o, atom0_o});
      ck("rd_upd", {er, eu}, {rd_data_o, atom_upd_o});
   end
   // Cycle ceiling against a hang
   always @(posedge clk_i) if (++cyc > 3000) begin
      fail_count++;
      finish_test();
   end
   // Reset, then random writes and reads across mapped and unmapped space
   initial begin
      void'($urandom(32'h21da1d39));
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1;
      repeat (3) @(posedge clk_i);
      go <= 1;
      repeat (2000) begin
         wr_en_i <= 1'($urandom);
         wr_addr_i <= 8'($urandom % 32 + 8);
         wr_data_i <= 8'($urandom);
         rd_addr_i <= 8'($urandom % 32 + 8);
         @(posedge clk_i);
      end
      finish_test();
   end
endmodule
